// ### gain_field_decode.sv
// one three-bit gain field decoded into a shift and an offset step
`timescale 1ns/1ns
`default_nettype none
module gain_field_decode
    import gain_offset_pkg::*;
(
    input wire logic [2:0] code,
    output logic [2:0] shift,
    output logic [10:0] step_uv,
    output logic legal
);
    // binary code 0..4 is gain 2**code, codes 5..7 are reserved and fall back to unity
    assign legal = (code <= GAIN_CODE_MAX); // RULE12
    assign shift = legal ? code : 3'h0; // RULE1 RULE2
    // step shrinks as the gain rises
    assign step_uv = (shift == 3'h0) ? STEP_UV_G1 : // RULE6
                     (shift == 3'h1) ? STEP_UV_G2 :
                     (shift == 3'h2) ? STEP_UV_G4 :
                     (shift == 3'h3) ? STEP_UV_G8 : STEP_UV_G16;
endmodule
`default_nettype wire

// ### gain_offset_pkg.sv
// package: register map, field layout, reset values and integrator constants
package gain_offset_pkg;
    localparam logic [3:0] ADDR_GAIN = 4'h0;
    localparam logic [3:0] ADDR_COFS = 4'h4;
    localparam logic [3:0] ADDR_VOFS = 4'h8;
    localparam logic [3:0] ADDR_SAMPLE_IN = 4'hC;
    localparam int CGAIN_LSB = 0;
    localparam int RANGE_LSB = 3;
    localparam int VGAIN_LSB = 5;
    localparam int OFS_SIGN_BIT = 5;
    localparam int INTEG_EN_BIT = 7;
    localparam logic [7:0] GAIN_RESET = 8'h00;
    localparam logic [7:0] OFS_RESET = 8'h00;
    localparam logic [2:0] GAIN_CODE_MAX = 3'h4;
    localparam logic [1:0] RANGE_CODE_MAX = 2'h2;
    // leak shift of the integrator pole; larger means closer to a pure integrator
    localparam int INTEG_LEAK_SHIFT = 8;
    localparam int SAMPLE_W = 16;
    localparam int ACC_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // offset step per lsb in microvolts, unity gain through gain sixteen
    localparam logic [10:0] STEP_UV_G1 = 11'd1610;
    localparam logic [10:0] STEP_UV_G2 = 11'd1190;
    localparam logic [10:0] STEP_UV_G4 = 11'd970;
    localparam logic [10:0] STEP_UV_G8 = 11'd840;
    localparam logic [10:0] STEP_UV_G16 = 11'd770;
endpackage

// ### input_gain_offset_control.sv
// top: register slave on axi4-lite and front-end gain, range and offset control
// Function
// (RULE1) Current gain comes from gain bits 0..2 with gains 1, 2, 4, 8 and 16.
// (RULE2) Voltage gain comes from gain bits 5..7 with the same five gains.
// (RULE3) Gain bits 3 and 4 pick a current full scale of 0.5, 0.25 or 0.125 V.
// (RULE4) Each offset value is six bits, one sign bit and five magnitude bits.
// (RULE5) Software keeps offset magnitudes within 31 counts either way.
// (RULE6) The offset step shrinks as gain rises, 1.61 mV at unity to 0.77 mV at 16.
// (RULE7) The integrator is off after reset until software turns it on.
// (RULE8) The current offset top bit enables the integrator, clear bypasses it.
// (RULE9) Software cancels offset with opposite sign on current, same sign on voltage.
// (RULE10) Software should bypass integrator and high-pass filter while trimming.
// (RULE11) The enabled integrator falls 20 dB per decade with about -90 degrees.
// (RULE12) Gain codes 0..4 select 1..16, other codes are reserved.
`timescale 1ns/1ns
`default_nettype none
module input_gain_offset_control
    import gain_offset_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sample_valid,
    input wire logic signed [SAMPLE_W-1:0] current_sample,
    output logic [2:0] current_gain_shift,
    output logic [2:0] voltage_gain_shift,
    output logic [1:0] current_range_sel,
    output logic signed [5:0] current_offset,
    output logic signed [5:0] voltage_offset,
    output logic [10:0] current_step_uv,
    output logic [10:0] voltage_step_uv,
    output logic integrator_on,
    output logic signed [SAMPLE_W-1:0] current_out
);
    logic [7:0] analog_gain_select;
    logic [7:0] current_offset_trim;
    logic [7:0] voltage_offset_trim;
    logic [3:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic [SAMPLE_W-1:0] last_out;

    // write channel: address and data may come in either order
    wire aw_take = ce && s_axi_awvalid && s_axi_awready;
    wire w_take = ce && s_axi_wvalid && s_axi_wready;
    wire do_write = ce && aw_held && w_held && !s_axi_bvalid;
    wire wr_gain = do_write && aw_addr == ADDR_GAIN && w_strb[0];
    wire wr_cofs = do_write && aw_addr == ADDR_COFS && w_strb[0];
    wire wr_vofs = do_write && aw_addr == ADDR_VOFS && w_strb[0];
    wire wr_hit = aw_addr == ADDR_GAIN || aw_addr == ADDR_COFS || aw_addr == ADDR_VOFS;
    // held flags one edge ahead, so the readies can leave straight from flip-flops
    wire next_aw_held = aw_take || (aw_held && !do_write);
    wire next_w_held = w_take || (w_held && !do_write);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held <= 1'b0;
            if (w_take)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (do_write)
                w_held <= 1'b0;
            // readies rise at the first enabled edge after reset, a cycle later than
            // a combinational ready would, in exchange for a clean registered output
            if (ce)
            begin
                s_axi_awready <= !next_aw_held;
                s_axi_wready <= !next_w_held;
            end
        end
    end

    // register file; reset clears the top bit so the integrator starts bypassed
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            analog_gain_select <= GAIN_RESET;
            current_offset_trim <= OFS_RESET; // RULE7
            voltage_offset_trim <= OFS_RESET;
        end
        else
        begin
            if (wr_gain)
                analog_gain_select <= w_data[7:0];
            if (wr_cofs)
                current_offset_trim <= w_data[7:0];
            if (wr_vofs)
                voltage_offset_trim <= w_data[7:0];
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // read path: one outstanding read, answered the cycle after the address
    wire ar_take = ce && s_axi_arvalid && s_axi_arready;
    wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
    wire rd_hit = s_axi_araddr == ADDR_GAIN || s_axi_araddr == ADDR_COFS ||
                  s_axi_araddr == ADDR_VOFS || s_axi_araddr == ADDR_SAMPLE_IN;
    wire [31:0] rd_mux = (s_axi_araddr == ADDR_GAIN) ? {24'h0, analog_gain_select} :
                         (s_axi_araddr == ADDR_COFS) ? {24'h0, current_offset_trim} :
                         (s_axi_araddr == ADDR_VOFS) ? {24'h0, voltage_offset_trim} :
                         (s_axi_araddr == ADDR_SAMPLE_IN) ? {16'h0, last_out} : 32'h0;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
        end
        else if (ce)
        begin
            if (ar_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
            // address is refused for as long as an answer waits
            s_axi_arready <= !next_rvalid;
        end
    end

    // field decode of the gain register
    wire [2:0] cgain_code = analog_gain_select[CGAIN_LSB +: 3];
    wire [2:0] vgain_code = analog_gain_select[VGAIN_LSB +: 3];
    wire [1:0] range_code = analog_gain_select[RANGE_LSB +: 2];
    wire [2:0] cshift;
    wire [2:0] vshift;
    wire [10:0] cstep;
    wire [10:0] vstep;
    gain_field_decode u_cgain (.code(cgain_code), .shift(cshift), .step_uv(cstep), .legal());
    gain_field_decode u_vgain (.code(vgain_code), .shift(vshift), .step_uv(vstep), .legal());
    // range 3 is not a documented choice, held at the narrowest range
    wire [1:0] range_sel = (range_code > RANGE_CODE_MAX) ? RANGE_CODE_MAX : range_code; // RULE3

    // sign-magnitude to two's complement; magnitude is at most 31 by construction
    function automatic logic signed [5:0] sm_to_tc(input logic [5:0] sm);
        logic [5:0] mag;
        mag = {1'b0, sm[4:0]};
        sm_to_tc = sm[OFS_SIGN_BIT] ? -mag : mag; // RULE4 RULE5
    endfunction
    wire signed [5:0] cofs = sm_to_tc(current_offset_trim[5:0]);
    wire signed [5:0] vofs = sm_to_tc(voltage_offset_trim[5:0]);
    wire integ_en = current_offset_trim[INTEG_EN_BIT]; // RULE8

    wire signed [SAMPLE_W-1:0] integ_out;
    leaky_integrator u_integ (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .enable(integ_en),
        .sample_valid(sample_valid),
        .sample_in(current_sample),
        .sample_out(integ_out)
    );

    // every control output is registered so the analog side sees clean levels
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            current_gain_shift <= 3'h0;
            voltage_gain_shift <= 3'h0;
            current_range_sel <= 2'h0;
            current_offset <= 6'sh00;
            voltage_offset <= 6'sh00;
            current_step_uv <= STEP_UV_G1;
            voltage_step_uv <= STEP_UV_G1;
            integrator_on <= 1'b0; // RULE7
            current_out <= '0;
            last_out <= '0;
        end
        else if (ce)
        begin
            current_gain_shift <= cshift; // RULE1
            voltage_gain_shift <= vshift; // RULE2
            current_range_sel <= range_sel; // RULE3
            current_offset <= cofs; // RULE4
            voltage_offset <= vofs;
            current_step_uv <= cstep; // RULE6
            voltage_step_uv <= vstep;
            integrator_on <= integ_en; // RULE8
            current_out <= integ_out;
            last_out <= integ_out;
        end
    end

    // checks next to the logic
    sequence s_cofs_write;
        wr_cofs;
    endsequence
    a_integ_follows_msb: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
        s_cofs_write ##1 ce |=> integrator_on == $past(current_offset_trim[INTEG_EN_BIT]))
        else $error("integrator enable does not follow offset msb");
    a_integ_off_reset: assert property (@(posedge aclk) // RULE7
        $rose(aresetn) |-> !integrator_on)
        else $error("integrator on right after reset");
    a_cgain_legal: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        current_gain_shift <= GAIN_CODE_MAX)
        else $error("current gain shift out of range");
    a_vgain_track: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
        ce && vgain_code <= GAIN_CODE_MAX |=> voltage_gain_shift == $past(vgain_code))
        else $error("voltage gain not taken from bits 5 to 7");
    a_reserved_unity: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
        ce && cgain_code > GAIN_CODE_MAX |=> current_gain_shift == 3'h0)
        else $error("reserved gain code not unity");
    a_range_track: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
        ce && range_code <= RANGE_CODE_MAX |=> current_range_sel == $past(range_code))
        else $error("range select not taken from bits 3 and 4");
    a_offset_sm: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
        ce |=> (current_offset < 0) == ($past(current_offset_trim[OFS_SIGN_BIT]) &&
                $past(current_offset_trim[4:0]) != 5'h00))
        else $error("offset sign decode wrong");
    a_step_order: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
        ce && cshift > vshift |=> current_step_uv < voltage_step_uv)
        else $error("offset step does not shrink with gain");
    a_bypass_pass: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
        ce && !integ_en |=> current_out == $past(current_sample))
        else $error("bypassed path altered the sample");
    // reserved range code falls back to the narrowest range
    a_range_reserved: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
        ce && range_code == 2'h3 |=> current_range_sel == RANGE_CODE_MAX)
        else $error("reserved range code not held at narrowest range");
    a_voffset_sm: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
        ce |=> (voltage_offset < 0) == ($past(voltage_offset_trim[OFS_SIGN_BIT]) &&
                $past(voltage_offset_trim[4:0]) != 5'h00))
        else $error("voltage offset sign decode wrong");
    a_unity_step: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
        ce && cshift == 3'h0 |=> current_step_uv == STEP_UV_G1)
        else $error("unity gain step is not the largest");
    a_top_step: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
        ce && vshift == GAIN_CODE_MAX |=> voltage_step_uv == STEP_UV_G16)
        else $error("gain sixteen step is not the smallest");
    // one read at a time: the address is refused while an answer waits
    sequence s_read_take;
        ar_take;
    endsequence
    sequence s_read_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_read_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read address taken without a read answer");
    a_read_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        s_read_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before it was taken");
    a_ready_apart: assert property (@(posedge aclk) disable iff (!aresetn)
        !(s_axi_arready && s_axi_rvalid))
        else $error("read address open while an answer waits");
endmodule
`default_nettype wire

// ### leaky_integrator.sv
// first-order digital integrator, -20 dB/dec above its pole, about -90 degrees
`timescale 1ns/1ns
`default_nettype none
module leaky_integrator
    import gain_offset_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic enable,
    input wire logic sample_valid,
    input wire logic signed [SAMPLE_W-1:0] sample_in,
    output logic signed [SAMPLE_W-1:0] sample_out
);
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] next_acc;
    // leak keeps dc from winding the accumulator up; trades low-frequency accuracy
    assign next_acc = acc + ACC_W'(sample_in) - (acc >>> INTEG_LEAK_SHIFT); // RULE11
    // bypassed the accumulator is held clear so enabling starts clean
    always_ff @(posedge aclk)
    begin
        if (!aresetn || (ce && !enable))
            acc <= '0;
        else if (ce && sample_valid)
            acc <= next_acc;
    end
    assign sample_out = enable ? acc[ACC_W-1 -: SAMPLE_W] : sample_in; // RULE8
endmodule
`default_nettype wire

// ### tb_input_gain_offset_control.sv
// testbench: register access over axi4-lite and front-end control outputs
`timescale 1ns/1ns
`default_nettype none
module tb_input_gain_offset_control;
import gain_offset_pkg::*;
logic aclk, aresetn, ce;
logic [3:0] awaddr, araddr, wstrb;
logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
logic [31:0] wdata, rdata;
logic [1:0] bresp, rresp, range_sel;
logic sample_valid, integ_on;
logic signed [SAMPLE_W-1:0] sample, cur_out;
logic [2:0] cshift, vshift;
logic signed [5:0] cofs, vofs;
logic [10:0] cstep, vstep;
logic [1:0] resp;
logic [31:0] rd;
int num_errors = 0;
int checks_done = 0;
input_gain_offset_control i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_valid(sample_valid), .current_sample(sample), .current_gain_shift(cshift),
    .voltage_gain_shift(vshift), .current_range_sel(range_sel), .current_offset(cofs),
    .voltage_offset(vofs), .current_step_uv(cstep), .voltage_step_uv(vstep),
    .integrator_on(integ_on), .current_out(cur_out));
// free-running clock, 10 ns period
initial
begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
end
task automatic close_out();
    if (num_errors == 0 && checks_done > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
        num_errors++;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
endtask
// handshakes are judged at the falling edge, so a combinational ready never races the tb
task automatic axi_write(input logic [3:0] a, input logic [7:0] d, input logic [3:0] st);
    logic aw, w, b;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= {24'h000000, d}; wstrb <= st;
    wvalid <= 1'b1; bready <= 1'b1;
    while (!b)
    begin
        @(negedge aclk);
        aw = awvalid && awready; w = wvalid && wready; b = bvalid; resp = bresp;
        @(posedge aclk);
        if (aw) awvalid <= 1'b0;
        if (w) wvalid <= 1'b0;
        if (b) bready <= 1'b0;
    end
endtask
task automatic axi_read(input logic [3:0] a);
    logic ar, r;
    r = 1'b0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!r)
    begin
        @(negedge aclk);
        ar = arvalid && arready; r = rvalid; rd = rdata; resp = rresp;
        @(posedge aclk);
        if (ar) arvalid <= 1'b0;
        if (r) rready <= 1'b0;
    end
endtask
// outputs follow the register one edge later, so let two edges pass
task automatic settle();
    repeat (2) @(posedge aclk);
    @(negedge aclk);
endtask
function automatic logic [2:0] shift_of(input logic [2:0] c);
    return (c <= 3'h4) ? c : 3'h0;
endfunction
function automatic logic [10:0] step_of(input logic [2:0] c);
    case (c)
        3'h1: return STEP_UV_G2;
        3'h2: return STEP_UV_G4;
        3'h3: return STEP_UV_G8;
        3'h4: return STEP_UV_G16;
        default: return STEP_UV_G1;
    endcase
endfunction
function automatic logic signed [5:0] ofs_of(input logic [7:0] d);
    return d[5] ? 6'h00 - {1'b0, d[4:0]} : {1'b0, d[4:0]};
endfunction
// watchdog: the whole sequence needs a few hundred cycles
initial
begin
    #200000;
    num_errors++;
    close_out();
end
initial
begin
    logic [7:0] g, ofs[5];
    ofs = '{8'h1F, 8'h3F, 8'h21, 8'h20, 8'h05};
    aresetn = 1'b0; ce = 1'b1; awaddr = 4'h0; araddr = 4'h0; wstrb = 4'h0; wdata = 32'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    sample_valid = 1'b1; sample = 16'sh0000;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(integ_on, 1'b0);
    chk(cstep, STEP_UV_G1);
    axi_read(ADDR_GAIN); chk(rd, 32'h0);
    axi_read(ADDR_COFS); chk(rd, 32'h0);
    axi_read(4'h2); chk(resp, RESP_SLVERR);
    // every gain and range code on both channels
    for (int i = 0; i < 8; i++)
    begin
        g = {3'(7 - i), 2'(i), 3'(i)};
        axi_write(ADDR_GAIN, g, 4'hF); chk(resp, RESP_OKAY);
        settle();
        chk(cshift, shift_of(g[2:0]));
        chk(vshift, shift_of(g[7:5]));
        chk(range_sel, (g[4:3] == 2'h3) ? 2'h2 : g[4:3]);
        chk(cstep, step_of(g[2:0]));
        chk(vstep, step_of(g[7:5]));
        axi_read(ADDR_GAIN); chk(rd, {24'h0, g});
    end
    // disabled byte lane leaves the gain unchanged
    axi_write(ADDR_GAIN, 8'h12, 4'hE); chk(resp, RESP_OKAY);
    axi_read(ADDR_GAIN); chk(rd, {24'h0, g});
    // sign-magnitude offsets, negative zero included
    for (int i = 0; i < 5; i++)
    begin
        axi_write(ADDR_COFS, ofs[i] ^ 8'h20, 4'hF);
        axi_write(ADDR_VOFS, ofs[i], 4'hF);
        settle();
        chk(cofs, ofs_of(ofs[i] ^ 8'h20));
        chk(vofs, ofs_of(ofs[i]));
        chk(integ_on, 1'b0);
    end
    // integrator on: a step input ramps up slowly instead of passing through
    axi_write(ADDR_COFS, 8'h85, 4'hF);
    settle();
    chk(integ_on, 1'b1);
    chk(cofs, 6'h05);
    @(posedge aclk);
    sample <= 16'sh4000;
    repeat (64) @(posedge aclk);
    @(negedge aclk);
    chk((cur_out > 0) && (cur_out < 16'sh4000), 1'b1);
    // integrator off again: sample passes one cycle late
    axi_write(ADDR_COFS, 8'h00, 4'hF);
    sample <= 16'sh1234;
    settle();
    chk(integ_on, 1'b0);
    chk(cur_out, 32'h1234);
    axi_read(ADDR_SAMPLE_IN); chk(rd, 32'h1234);
    // clock enable low freezes the output path, release lets the new sample through
    @(posedge aclk);
    ce <= 1'b0;
    sample <= 16'sh0F0F;
    settle();
    chk(cur_out, 32'h1234);
    @(posedge aclk);
    ce <= 1'b1;
    settle();
    chk(cur_out, 32'h0F0F);
    close_out();
end
endmodule
`default_nettype wire
